// [hdl/cifs_pkg.sv]
// Package for the charger input and fault status register bank.
// Assumes a 32-bit APB master and on-chip monitors driving condition levels.
package cifs_pkg;
  // Register indices; each register takes one aligned word, so its byte address is index * 4.
  localparam logic [7:0] CIFS_IDX_CHG_STATE = 8'h02;
  localparam logic [7:0] CIFS_IDX_THM_STATE = 8'h03;
  localparam logic [7:0] CIFS_IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] CIFS_IDX_IRQ_MASK = 8'h11;
  localparam logic [9:0] CIFS_ADDR_CHG_STATE = {CIFS_IDX_CHG_STATE, 2'b00};
  localparam logic [9:0] CIFS_ADDR_THM_STATE = {CIFS_IDX_THM_STATE, 2'b00};
  localparam logic [9:0] CIFS_ADDR_IRQ_STATUS = {CIFS_IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] CIFS_ADDR_IRQ_MASK = {CIFS_IDX_IRQ_MASK, 2'b00};
  // Field positions in the charger input state register.
  localparam int CIFS_B_INPUT_CURRENT_LIMITING = 5;
  localparam int CIFS_B_OVP = 4;
  localparam int CIFS_B_VALID = 3;
  localparam int CIFS_B_TP_SD = 2;
  localparam int CIFS_B_TP_RED = 1;
  localparam int CIFS_B_TMO = 0;
  // Field positions in the thermal and undervoltage state register.
  localparam int CIFS_B_LIM_OT = 7;
  localparam int CIFS_B_REG_OT = 5;
  localparam int CIFS_B_LDO2_UV = 4;
  localparam int CIFS_B_LDO1_UV = 3;
  // Reset values.
  localparam logic [7:0] CIFS_RST_STATE = 8'h00;
  localparam logic [9:0] CIFS_RST_IRQ = 10'h000;
  // Monitor condition levels.
  typedef struct packed {
    logic input_current_limiting;
    logic input_overvoltage_flag;
    logic input_supply_valid;
    logic temp_profile_charge_shutdown;
    logic temp_profile_charge_reduction;
    logic charge_timeout_flag;
    logic limiter_charger_overtemp;
    logic ldo1_overtemp;
    logic ldo2_overtemp;
    logic lsw1_overtemp;
    logic lsw2_overtemp;
    logic second_linear_reg_lockout;
    logic first_linear_reg_lockout;
  } cifs_mon_t;
endpackage : cifs_pkg

// [hdl/cifs_regs.sv]
// Charger input and fault status register bank with APB slave and interrupt.
// Assumes monitor levels synchronous to pclk; APB master per the AMBA APB protocol.
`timescale 1ns/100ps
module cifs_regs (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitor conditions.
  input wire cifs_pkg::cifs_mon_t mon,
  // Interrupt.
  output logic irq
);

  // Selection of the state register fields, registered below.
  logic [7:0] chg_state_q;
  logic [7:0] chg_state_d;
  logic [7:0] thm_state_q;
  logic [7:0] thm_state_d;
  // Sticky event status and mask, one bit per state field.
  logic [9:0] irq_status_q;
  logic [9:0] irq_status_d;
  logic [9:0] irq_mask_q;
  logic [9:0] irq_mask_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  // Input qualification: overvoltage/valid pair equals 01.
  wire input_ok = !mon.input_overvoltage_flag && mon.input_supply_valid;
  // Regulator and switch thermal shutdowns gathered into one flag.
  wire reg_ot = mon.ldo1_overtemp | mon.ldo2_overtemp |
                mon.lsw1_overtemp | mon.lsw2_overtemp;

  // Build the charger input state byte; qualified flags read 0 without valid input.
  always_comb
  begin
    chg_state_d = cifs_pkg::CIFS_RST_STATE;
    chg_state_d[cifs_pkg::CIFS_B_INPUT_CURRENT_LIMITING] = mon.input_current_limiting & input_ok;
    chg_state_d[cifs_pkg::CIFS_B_OVP] = mon.input_overvoltage_flag;
    chg_state_d[cifs_pkg::CIFS_B_VALID] = mon.input_supply_valid;
    chg_state_d[cifs_pkg::CIFS_B_TP_SD] = mon.temp_profile_charge_shutdown & input_ok;
    chg_state_d[cifs_pkg::CIFS_B_TP_RED] = mon.temp_profile_charge_reduction & input_ok;
    chg_state_d[cifs_pkg::CIFS_B_TMO] = mon.charge_timeout_flag & input_ok;
  end

  // Build the thermal and undervoltage state byte.
  always_comb
  begin
    thm_state_d = cifs_pkg::CIFS_RST_STATE;
    thm_state_d[cifs_pkg::CIFS_B_LIM_OT] = mon.limiter_charger_overtemp;
    thm_state_d[cifs_pkg::CIFS_B_REG_OT] = reg_ot;
    thm_state_d[cifs_pkg::CIFS_B_LDO2_UV] = mon.second_linear_reg_lockout;
    thm_state_d[cifs_pkg::CIFS_B_LDO1_UV] = mon.first_linear_reg_lockout;
  end

  // APB decode; the slave always answers in the first access cycle.
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // Selects include the upper address bits so an unmapped alias can never write a register.
  wire page0 = paddr[11:10] == 2'b00;
  wire sel_chg = page0 && (paddr[9:0] == cifs_pkg::CIFS_ADDR_CHG_STATE);
  wire sel_thm = page0 && (paddr[9:0] == cifs_pkg::CIFS_ADDR_THM_STATE);
  wire sel_sts = page0 && (paddr[9:0] == cifs_pkg::CIFS_ADDR_IRQ_STATUS);
  wire sel_msk = page0 && (paddr[9:0] == cifs_pkg::CIFS_ADDR_IRQ_MASK);
  wire hit = sel_chg || sel_thm || sel_sts || sel_msk;
  wire lo_wr = wr && pstrb[0];
  wire hi_wr = wr && pstrb[1];
  // Rising edges of state fields become events; all ten fields packed together.
  wire [9:0] fields = {chg_state_q[5:0], thm_state_q[7], thm_state_q[5:3]};
  wire [9:0] fields_n = {chg_state_d[5:0], thm_state_d[7], thm_state_d[5:3]};
  wire [9:0] rise = fields_n & ~fields;
  wire [9:0] w1c = {(hi_wr ? pwdata[9:8] : 2'b00), (lo_wr ? pwdata[7:0] : 8'h00)};
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // Status: set wins over a write-one clear in the same cycle.
  assign irq_status_d = rise | (irq_status_q & ~((wr && sel_sts) ? w1c : 10'h000));
  // Mask writes; state registers ignore writes entirely.
  always_comb
  begin
    irq_mask_d = irq_mask_q;
    if (wr && sel_msk)
    begin
      if (pstrb[0]) irq_mask_d[7:0] = pwdata[7:0];
      if (pstrb[1]) irq_mask_d[9:8] = pwdata[9:8];
    end
  end

  // Read data mux; unused bits read zero.
  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite)
    begin
      prdata_d = 32'h0000_0000;
      if (sel_chg) prdata_d[7:0] = chg_state_d;
      if (sel_thm) prdata_d[7:0] = thm_state_d;
      if (sel_sts) prdata_d[9:0] = irq_status_d;
      if (sel_msk) prdata_d[9:0] = irq_mask_d;
      if (paddr[11:10] != 2'b00) prdata_d = 32'h0000_0000;
    end
  end
  assign prdata = prdata_q;

  // State registers track the monitors every cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chg_state_q <= cifs_pkg::CIFS_RST_STATE;
      thm_state_q <= cifs_pkg::CIFS_RST_STATE;
      irq_status_q <= cifs_pkg::CIFS_RST_IRQ;
      irq_mask_q <= cifs_pkg::CIFS_RST_IRQ;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      chg_state_q <= chg_state_d;
      thm_state_q <= thm_state_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
    end
  end

  // Interrupt is a level while any unmasked status bit is set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(irq_status_d & irq_mask_d);
  end

  // Checks.
  a_input_current_limiting_qual: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[5] |-> (chg_state_q[3] && !chg_state_q[4])) else $error("input_current_limiting unqualified");
  a_input_current_limiting_map: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[5] == $past(mon.input_current_limiting & input_ok)) else $error("input_current_limiting");
  a_ovp_map: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[4] == $past(mon.input_overvoltage_flag)) else $error("ovp");
  a_valid_map: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[3] == $past(mon.input_supply_valid)) else $error("valid");
  a_tp_map: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[2:1] == ($past({mon.temp_profile_charge_shutdown,
    mon.temp_profile_charge_reduction}) & {2{$past(input_ok)}})) else $error("tp");
  a_tmo_map: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[0] == $past(mon.charge_timeout_flag & input_ok)) else $error("tmo");
  a_limot_map: assert property (@(posedge pclk) disable iff (!presetn)
    thm_state_q[7] == $past(mon.limiter_charger_overtemp)) else $error("limot");
  a_regot_map: assert property (@(posedge pclk) disable iff (!presetn)
    thm_state_q[5] == $past(reg_ot)) else $error("regot");
  a_uv_map: assert property (@(posedge pclk) disable iff (!presetn)
    thm_state_q[4:3] == $past({mon.second_linear_reg_lockout,
    mon.first_linear_reg_lockout})) else $error("uv");
  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    chg_state_q[7:6] == 2'b00 && thm_state_q[6] == 1'b0 && thm_state_q[2:0] == 3'b000)
    else $error("unused bits");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(irq_status_d) & $past(irq_mask_d))) else $error("irq");

  // Bus steps used by the checks below; each names one phase of one kind of transfer.
  // A status write with no rising field in the same cycle clears exactly what is written.
  sequence s_sts_quiet_write;
    psel && penable && pwrite && sel_sts && (rise == 10'h000);
  endsequence

  // Mask write through byte lane zero.
  sequence s_msk_low_write;
    psel && penable && pwrite && sel_msk && pstrb[0];
  endsequence

  // Mask write through byte lane one.
  sequence s_msk_high_write;
    psel && penable && pwrite && sel_msk && pstrb[1];
  endsequence

  // Read setup cycles to each register; read data is captured at this edge.
  sequence s_rd_chg_setup;
    psel && !penable && !pwrite && sel_chg;
  endsequence

  // Read setup to the thermal and undervoltage register.
  sequence s_rd_thm_setup;
    psel && !penable && !pwrite && sel_thm;
  endsequence

  // Read setup to the interrupt status register.
  sequence s_rd_sts_setup;
    psel && !penable && !pwrite && sel_sts;
  endsequence

  // Read setup to the interrupt mask register.
  sequence s_rd_msk_setup;
    psel && !penable && !pwrite && sel_msk;
  endsequence

  // The slave never inserts wait states.
  // A low ready here would stall every master forever.
  a_pready_tie:
    assert property (@(posedge pclk) disable iff (!presetn) pready)
    else $error("pready low");

  // The error response marks exactly the accesses that hit no register.
  // Software relies on it to find a wrong address.
  a_slverr_map:
    assert property (@(posedge pclk) disable iff (!presetn) pslverr == (acc && !hit))
    else $error("pslverr map");

  // Outside an access phase the error response stays low.
  // A stray error would be blamed on the wrong transfer.
  a_slverr_idle:
    assert property (@(posedge pclk) disable iff (!presetn) !acc |-> !pslverr)
    else $error("pslverr idle");

  // A write to the charger state leaves it following the monitors only.
  // The register has no storage that software could reach.
  a_chg_ro:
    assert property (@(posedge pclk) disable iff (!presetn) (wr && sel_chg) |=> chg_state_q == $past(chg_state_d))
    else $error("charger state written");

  // A write to the thermal state leaves it following the monitors only.
  // The same holds for every lane and every data value.
  a_thm_ro:
    assert property (@(posedge pclk) disable iff (!presetn) (wr && sel_thm) |=> thm_state_q == $past(thm_state_d))
    else $error("thermal state written");

  // A rising field always leaves its status bit set one edge later.
  // No event may be lost, whatever the bus does meanwhile.
  a_sts_set:
    assert property (@(posedge pclk) disable iff (!presetn) (rise != 10'h000) |=> ((irq_status_q & $past(rise)) == $past(rise)))
    else $error("status event lost");

  // A quiet status write clears exactly the bits written as one.
  // Bits written as zero keep their value.
  a_sts_clear:
    assert property (@(posedge pclk) disable iff (!presetn) s_sts_quiet_write |=> irq_status_q == ($past(irq_status_q) & ~$past(w1c)))
    else $error("status clear");

  // With no event and no status write, the status holds.
  // Reads must never disturb sticky bits.
  a_sts_hold:
    assert property (@(posedge pclk) disable iff (!presetn) (!(wr && sel_sts) && (rise == 10'h000)) |=> $stable(irq_status_q))
    else $error("status drift");

  // An event in the cycle of its own clear keeps the bit set.
  // The clear loses so that software never misses the event.
  a_set_wins:
    assert property (@(posedge pclk) disable iff (!presetn) (wr && sel_sts && ((rise & w1c) != 10'h000)) |=> ((irq_status_q & $past(rise & w1c)) == $past(rise & w1c)))
    else $error("clear beat set");

  // A status bit only appears after an event on its field.
  // Writing ones must never set a status bit.
  a_sts_source:
    assert property (@(posedge pclk) disable iff (!presetn) 1'b1 |=> ((irq_status_q & ~$past(irq_status_q) & ~$past(rise)) == 10'h000))
    else $error("status set without event");

  // Lane zero writes the low eight mask bits.
  // The upper lane is checked separately.
  a_mask_low:
    assert property (@(posedge pclk) disable iff (!presetn) s_msk_low_write |=> irq_mask_q[7:0] == $past(pwdata[7:0]))
    else $error("mask low lane");

  // Lane one writes the two upper mask bits.
  // Together the lanes cover all ten events.
  a_mask_high:
    assert property (@(posedge pclk) disable iff (!presetn) s_msk_high_write |=> irq_mask_q[9:8] == $past(pwdata[9:8]))
    else $error("mask high lane");

  // The mask changes only by a write to it.
  // Writes to other addresses must not leak into it.
  a_mask_hold:
    assert property (@(posedge pclk) disable iff (!presetn) !(wr && sel_msk) |=> $stable(irq_mask_q))
    else $error("mask drift");

  // The interrupt level matches the registered status and mask.
  // Both are loaded at the same edge as the interrupt flop.
  a_irq_now:
    assert property (@(posedge pclk) disable iff (!presetn) irq == |(irq_status_q & irq_mask_q))
    else $error("irq level");

  // With everything masked the interrupt stays low.
  // A masked event must stay silent.
  a_irq_masked:
    assert property (@(posedge pclk) disable iff (!presetn) (irq_mask_q == 10'h000) |-> !irq)
    else $error("irq while masked");

  // A read of the charger state returns its byte with zero above.
  // Data is captured at the setup edge and held for the access.
  a_rd_chg:
    assert property (@(posedge pclk) disable iff (!presetn) s_rd_chg_setup |=> prdata == {24'h00_0000, $past(chg_state_d)})
    else $error("charger state read");

  // A read of the thermal state returns its byte with zero above.
  // Unused positions inside the byte read zero as well.
  a_rd_thm:
    assert property (@(posedge pclk) disable iff (!presetn) s_rd_thm_setup |=> prdata == {24'h00_0000, $past(thm_state_d)})
    else $error("thermal state read");

  // A status read returns all ten sticky bits.
  // Upper bits of the word read zero.
  a_rd_sts:
    assert property (@(posedge pclk) disable iff (!presetn) s_rd_sts_setup |=> prdata == {22'h00_0000, $past(irq_status_d)})
    else $error("status read");

  // A mask read returns the ten mask bits.
  // Upper bits of the word read zero.
  a_rd_msk:
    assert property (@(posedge pclk) disable iff (!presetn) s_rd_msk_setup |=> prdata == {22'h00_0000, $past(irq_mask_d)})
    else $error("mask read");

  // A read of an unmapped address returns zero.
  // Old data must not leak to the wrong address.
  a_rd_unmapped:
    assert property (@(posedge pclk) disable iff (!presetn) (psel && !penable && !pwrite && !hit) |=> prdata == 32'h0000_0000)
    else $error("unmapped read data");

  // Outside a read setup the read data holds.
  // The master may sample it anywhere in the access phase.
  a_rd_hold:
    assert property (@(posedge pclk) disable iff (!presetn) !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");

  // Timeout and temperature profile flags need a valid supply.
  // Without it they read zero rather than stale values.
  a_qual_flags:
    assert property (@(posedge pclk) disable iff (!presetn) (chg_state_q[2:0] != 3'b000) |-> (chg_state_q[3] && !chg_state_q[4]))
    else $error("charger flags unqualified");

  // Overvoltage blanks every qualified flag.
  // The pair then differs from the valid code.
  a_ovp_blocks:
    assert property (@(posedge pclk) disable iff (!presetn) chg_state_q[4] |-> (!chg_state_q[5] && (chg_state_q[2:0] == 3'b000)))
    else $error("flags under overvoltage");

  // With no regulator or switch hot the combined flag is clear.
  // A stuck combined flag would hide recovery.
  a_regot_clear:
    assert property (@(posedge pclk) disable iff (!presetn) !$past(reg_ot) |-> !thm_state_q[5])
    else $error("regulator overtemp stuck");

endmodule : cifs_regs

// [dv/tb_top.sv]
// Self-checking bench for the charger input and fault status register bank.
// Assumes the package address map and an APB slave that signals completion on pready.
`timescale 1ns/100ps
module tb_top;
  // Clock, reset, APB and monitor drive.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  cifs_pkg::cifs_mon_t mon = '0;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  // Byte addresses of the four registers.
  localparam logic [11:0] A_CHG = {2'b00, cifs_pkg::CIFS_ADDR_CHG_STATE};
  localparam logic [11:0] A_THM = {2'b00, cifs_pkg::CIFS_ADDR_THM_STATE};
  localparam logic [11:0] A_ST = {2'b00, cifs_pkg::CIFS_ADDR_IRQ_STATUS};
  localparam logic [11:0] A_MK = {2'b00, cifs_pkg::CIFS_ADDR_IRQ_MASK};
  // Monitor patterns and the register images they must produce.
  localparam logic [12:0] MV [10] = '{13'h1780, 13'h1F80, 13'h1000, 13'h0040, 13'h0020,
    13'h0010, 13'h0008, 13'h0004, 13'h0002, 13'h0001};
  localparam logic [7:0] CE [10] = '{8'h2F, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  localparam logic [7:0] TE [10] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h20, 8'h20, 8'h20,
    8'h20, 8'h10, 8'h08};

  // Device under test.
  cifs_regs cifs_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mon(mon), .irq(irq));

  // Free-running clock at 200 MHz.
  always #2.5 pclk = ~pclk;

  // Cuts a hang short and goes to the report.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      mismatches = mismatches + 1;
      results();
    end
  end

  // Compares a seen value with the expected one.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is seen at a rising edge, for at most 50 edges.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n = n + 1;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads a register and compares it.
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rdchk

  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Main sequence: reset, status images, read-only writes, refusal, interrupt.
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_CHG, 32'h0);
    rdchk(A_THM, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      mon <= cifs_pkg::cifs_mon_t'(MV[i]);
      repeat (3) @(posedge pclk);
      rdchk(A_CHG, {24'h0, CE[i]});
      rdchk(A_THM, {24'h0, TE[i]});
    end
    apb(1'b1, A_CHG, 32'hFFFFFFFF, rd, err);
    apb(1'b1, A_THM, 32'hFFFFFFFF, rd, err);
    rdchk(A_CHG, 32'h0);
    rdchk(A_THM, 32'h8);
    apb(1'b0, 12'h020, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    mon <= '0;
    rdchk(A_ST, 32'h3FF);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_MK, 32'h3FF, rd, err);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_ST, 32'h3FF, rd, err);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdchk(A_ST, 32'h0);
    rdchk(A_MK, 32'h3FF);
    apb(1'b1, A_MK, 32'h1, rd, err);
    mon <= cifs_pkg::cifs_mon_t'(13'h0001);
    repeat (4) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    results();
  end
endmodule : tb_top
